// ==== hdl/delay_by_time_trigger.sv ====
// Delay-by-time trigger qualifier with its AHB-Lite register slave
`include "delay_trig_params.svh"

// What this block does
// - Arm on chosen edge, wait the delay, fire on next trigger edge.
// - Wait counted from arming, clamped to 50 ns (one cycle) .. 160 ms.
// - Trigger edge uses the arm threshold; no separate trigger level.
// - Analog arm source 1-2 on two-channel parts, else 1-4.
// - Mixed-signal parts also accept digital channels 0 to 15.
// - External arm source only on two-channel parts, else rejected.
// - Arm slope rising or falling, read back as stored.
// - Selected advanced mode and delay variant read back.
// - Event-variant trigger slope settable and read back.
// - Arm source reads back as stored: analog, digital or external.
// - Path has retrigger inhibit and noise reject conditioning.
module delay_by_time_trigger #(
  parameter int unsigned MAX_DELAY_CYC = `DLY_MAX_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Variant straps
  input  wire logic        variant_two_channel,
  input  wire logic        variant_mixed_signal,
  // Trigger inputs
  input  wire logic [3:0]  analog_cmp,
  input  wire logic [15:0] digital_in,
  input  wire logic        ext_trig_in,
  // Trigger outputs
  output logic [15:0]      edge_threshold,
  output logic             trig_fire,
  output logic             trig_armed
);

  localparam int SYNC_W = 23;

  // Source selection is legal for this variant
  function automatic logic src_ok(input delay_trig_pkg::src_sel_t s,
                                  input logic two_ch,
                                  input logic mixed);
    logic ok;
    ok = 1'b0;
    case (s.kind)
      delay_trig_pkg::SRC_ANALOG:
        ok = (s.idx >= 4'h1) && (s.idx <= (two_ch ? 4'h2 : 4'h4));
      delay_trig_pkg::SRC_DIGITAL:   ok = mixed;
      delay_trig_pkg::SRC_EXTERNAL:  ok = two_ch && (s.idx == 4'h0);
      default:                       ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Picks the input line that a source names
  function automatic logic src_pick(input delay_trig_pkg::src_sel_t s,
                                    input logic [3:0] an,
                                    input logic [15:0] dg,
                                    input logic ex);
    logic v;
    v = 1'b0;
    case (s.kind)
      delay_trig_pkg::SRC_ANALOG:   v = an[2'(s.idx - 4'h1)];
      delay_trig_pkg::SRC_DIGITAL:  v = dg[s.idx];
      delay_trig_pkg::SRC_EXTERNAL: v = ex;
      default:                      v = 1'b0;
    endcase
    return v;
  endfunction

  // Edge of the chosen polarity, 1 = rising
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    return rising ? (!prev && cur) : (prev && !cur);
  endfunction

  // Delay clamped to the supported range
  function automatic logic [23:0] clamp_dly(input logic [31:0] v);
    logic [23:0] r;
    r = v[23:0];
    if (v < 32'(`DLY_MIN_CYC)) r = 24'(`DLY_MIN_CYC);
    else if (v > 32'(MAX_DELAY_CYC)) r = 24'(MAX_DELAY_CYC);
    return r;
  endfunction

  // Register state
  logic                       adv_sel_r;
  delay_trig_pkg::adv_mode_t  adv_mode_r;
  logic                       time_var_r;
  delay_trig_pkg::src_sel_t   arm_src_r;
  delay_trig_pkg::src_sel_t   trig_src_r;
  logic                       arm_rise_r;
  logic                       trig_rise_r;
  logic                       evt_rise_r;
  logic [23:0]                delay_cyc_r;
  logic [15:0]                level_r;
  logic [15:0]                inhibit_r;
  logic [15:0]                band_r;
  logic                       err_r;
  logic [15:0]                fire_cnt_r;
  delay_trig_pkg::ahb_ap_t    ap_r;
  logic                       ap_vld_r;
  logic [31:0]                hrdata_r;

  // Synchronisers, straps and filters
  logic [SYNC_W-1:0]          sync1_r;
  logic [SYNC_W-1:0]          sync2_r;
  logic                       strap_done_r;
  logic [1:0]                 strap_wait_r;
  logic                       two_ch_r;
  logic                       mixed_r;
  logic [1:0]                 filt_r;
  logic [1:0]                 prev_r;
  logic [15:0]                fcnt_r [2];

  // Qualifier
  delay_trig_pkg::qual_state_t st_r;
  delay_trig_pkg::qual_state_t st_nxt;
  logic [23:0]                cnt_r;
  logic [23:0]                cnt_nxt;
  logic                       fire_r;

  // Bus decode
  wire        ap_take  = hsel && htrans[1] && hready;
  wire        wr_now   = ap_vld_r && ap_r.wr;
  wire [7:0]  wa       = ap_r.addr;
  wire        wr_ctrl  = wr_now && (wa == `OFS_CTRL);
  wire        wr_arm   = wr_now && (wa == `OFS_ARM_SRC);
  wire        wr_trig  = wr_now && (wa == `OFS_TRIG_SRC);
  wire        wr_slope = wr_now && (wa == `OFS_SLOPES);
  wire        wr_dly   = wr_now && (wa == `OFS_DELAY);
  wire        wr_lvl   = wr_now && (wa == `OFS_LEVEL);
  wire        wr_inh   = wr_now && (wa == `OFS_INHIBIT);
  wire        wr_band  = wr_now && (wa == `OFS_BAND);
  wire        wr_stat  = wr_now && (wa == `OFS_STATUS);
  wire delay_trig_pkg::src_sel_t wsrc = hwdata[5:0];
  wire        wsrc_ok  = src_ok(wsrc, two_ch_r, mixed_r);
  wire        src_bad  = (wr_arm || wr_trig) && !wsrc_ok;

  // Engine runs only in advanced, delay, time-variant setup
  wire        run      = adv_sel_r && time_var_r &&
                         (adv_mode_r == delay_trig_pkg::ADV_DELAY);

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `OFS_CTRL:     rd_mux = {28'h000_0000, time_var_r, adv_mode_r,
                               adv_sel_r};
      `OFS_ARM_SRC:  rd_mux = {26'h000_0000, arm_src_r};
      `OFS_TRIG_SRC: rd_mux = {26'h000_0000, trig_src_r};
      `OFS_SLOPES:   rd_mux = {29'h0000_0000, evt_rise_r, trig_rise_r,
                               arm_rise_r};
      `OFS_DELAY:    rd_mux = {8'h00, delay_cyc_r};
      `OFS_LEVEL:    rd_mux = {16'h0000, level_r};
      `OFS_INHIBIT:  rd_mux = {16'h0000, inhibit_r};
      `OFS_BAND:     rd_mux = {16'h0000, band_r};
      `OFS_STATUS:   rd_mux = {fire_cnt_r, 9'h000, mixed_r, two_ch_r,
                               trig_armed, err_r, st_r};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus pipeline: address phase captured, read data registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_vld_r <= 1'b0;
      ap_r     <= '0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      ap_vld_r <= ap_take;
      ap_r     <= '{wr: hwrite, addr: haddr[7:0]};
      if (ap_take && !hwrite) hrdata_r <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Mode and slope registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adv_sel_r   <= 1'b0;
      adv_mode_r  <= delay_trig_pkg::ADV_NONE;
      time_var_r  <= 1'b0;
      arm_rise_r  <= 1'b1;
      trig_rise_r <= 1'b1;
      evt_rise_r  <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        adv_sel_r  <= hwdata[`CTRL_ADV_BIT];
        adv_mode_r <= delay_trig_pkg::adv_mode_t'(
                        hwdata[`CTRL_MODE_LSB +: 2]);
        time_var_r <= hwdata[`CTRL_VAR_BIT];
      end
      if (wr_slope) begin
        arm_rise_r  <= hwdata[`SLOPE_ARM_BIT];
        trig_rise_r <= hwdata[`SLOPE_TRIG_BIT];
        evt_rise_r  <= hwdata[`SLOPE_EVT_BIT];
      end
    end
  end

  // Sources, legal choices only; illegal ones flag an error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_src_r  <= '{kind: delay_trig_pkg::SRC_ANALOG, idx: `RST_SRC_IDX};
      trig_src_r <= '{kind: delay_trig_pkg::SRC_ANALOG, idx: `RST_SRC_IDX};
      err_r      <= 1'b0;
    end else begin
      if (wr_arm && wsrc_ok) arm_src_r <= wsrc;
      if (wr_trig && wsrc_ok) trig_src_r <= wsrc;
      if (src_bad) err_r <= 1'b1;
      else if (wr_stat && hwdata[`STAT_ERR_BIT]) err_r <= 1'b0;
    end
  end

  // Delay, level and conditioning registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_cyc_r <= 24'(`DLY_MIN_CYC);
      level_r     <= `RST_LEVEL;
      inhibit_r   <= `RST_INHIBIT;
      band_r      <= `RST_BAND;
    end else begin
      if (wr_dly) delay_cyc_r <= clamp_dly(hwdata);
      if (wr_lvl) level_r <= hwdata[15:0];
      if (wr_inh) inhibit_r <= hwdata[15:0];
      if (wr_band) band_r <= hwdata[15:0];
    end
  end

  // One threshold serves arm and trigger comparators
  assign edge_threshold = level_r;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {variant_mixed_signal, variant_two_channel, ext_trig_in,
                  digital_in, analog_cmp};
      sync2_r <= sync1_r;
    end
  end

  // Straps caught once, after the synchroniser holds pin values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      two_ch_r     <= 1'b0;
      mixed_r      <= 1'b0;
    end else if (strap_wait_r != 2'h2) begin
      strap_wait_r <= strap_wait_r + 2'h1;  // Sync chain still filling
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      two_ch_r     <= sync2_r[21];
      mixed_r      <= sync2_r[22];
    end
  end

  // Raw arm and trigger lines from the chosen sources
  wire [1:0] raw = {
    src_pick(trig_src_r, sync2_r[3:0], sync2_r[19:4], sync2_r[20]),
    src_pick(arm_src_r, sync2_r[3:0], sync2_r[19:4], sync2_r[20])};

  // Noise reject: a change must persist past the band
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_r <= 2'b00;
      prev_r <= 2'b00;
      fcnt_r <= '{default: 16'h0000};
    end else begin
      prev_r <= filt_r;
      for (int i = 0; i < 2; i++) begin
        if (raw[i] == filt_r[i]) begin
          fcnt_r[i] <= 16'h0000;
        end else if (fcnt_r[i] >= band_r) begin
          filt_r[i] <= raw[i];
          fcnt_r[i] <= 16'h0000;
        end else begin
          fcnt_r[i] <= fcnt_r[i] + 16'h0001;
        end
      end
    end
  end

  wire arm_edge  = edge_hit(prev_r[0], filt_r[0], arm_rise_r);
  wire trig_edge = edge_hit(prev_r[1], filt_r[1], trig_rise_r);

  // Qualifier sequence
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      delay_trig_pkg::ST_IDLE:
        if (run) st_nxt = delay_trig_pkg::ST_WAIT;
      delay_trig_pkg::ST_WAIT:
        if (arm_edge) begin
          st_nxt  = delay_trig_pkg::ST_DELAY;
          cnt_nxt = delay_cyc_r - 24'h00_0001;
        end
      delay_trig_pkg::ST_DELAY:
        if (cnt_r == 24'h00_0000) st_nxt = delay_trig_pkg::ST_SEEK;
        else cnt_nxt = cnt_r - 24'h00_0001;
      delay_trig_pkg::ST_SEEK:
        if (trig_edge) begin
          st_nxt  = delay_trig_pkg::ST_INHIBIT;
          cnt_nxt = {8'h00, inhibit_r};
        end
      delay_trig_pkg::ST_INHIBIT:
        if (cnt_r == 24'h00_0000) st_nxt = delay_trig_pkg::ST_WAIT;
        else cnt_nxt = cnt_r - 24'h00_0001;
      default:
        st_nxt = delay_trig_pkg::ST_IDLE;
    endcase
    if (!run) st_nxt = delay_trig_pkg::ST_IDLE;
  end

  wire fire_now = run && (st_r == delay_trig_pkg::ST_SEEK) && trig_edge;

  // Qualifier state, fire pulse and fire count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= delay_trig_pkg::ST_IDLE;
      cnt_r      <= 24'h00_0000;
      fire_r     <= 1'b0;
      fire_cnt_r <= 16'h0000;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      fire_r <= fire_now;
      if (fire_now) fire_cnt_r <= fire_cnt_r + 16'h0001;
    end
  end

  assign trig_fire  = fire_r;
  assign trig_armed = (st_r == delay_trig_pkg::ST_DELAY) ||
                      (st_r == delay_trig_pkg::ST_SEEK);

endmodule // delay_by_time_trigger

// ==== hdl/delay_trig_params.svh ====
// Offsets, field positions, reset values and timing counts of the qualifier
`ifndef DELAY_TRIG_PARAMS_SVH
`define DELAY_TRIG_PARAMS_SVH
// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_ARM_SRC   8'h04
`define OFS_TRIG_SRC  8'h08
`define OFS_SLOPES    8'h0C
`define OFS_DELAY     8'h10
`define OFS_LEVEL     8'h14
`define OFS_INHIBIT   8'h18
`define OFS_BAND      8'h1C
`define OFS_STATUS    8'h20
// Field positions
`define CTRL_ADV_BIT     0
`define CTRL_MODE_LSB    1
`define CTRL_VAR_BIT     3
`define SLOPE_ARM_BIT    0
`define SLOPE_TRIG_BIT   1
`define SLOPE_EVT_BIT    2
`define STAT_ERR_BIT     3
// Reset values
`define RST_CTRL      4'h0
`define RST_SRC_IDX   4'h1
`define RST_LEVEL     16'h8000
`define RST_INHIBIT   16'h0000
`define RST_BAND      16'h0000
// Timing: figures in ns, counts in 50 ns cycles
`define CLK_PERIOD_NS 50
`define DLY_MIN_NS    30
`define DLY_MAX_NS    160000000
`define DLY_MIN_CYC   ((`DLY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_MAX_CYC   (`DLY_MAX_NS / `CLK_PERIOD_NS)
`endif

// ==== hdl/delay_trig_pkg.sv ====
// Types shared by the delayed trigger qualifier
package delay_trig_pkg;
  typedef enum logic [1:0] {
    SRC_ANALOG   = 2'b00,
    SRC_DIGITAL  = 2'b01,
    SRC_EXTERNAL = 2'b10
  } src_kind_t;

  typedef struct packed {
    src_kind_t  kind;
    logic [3:0] idx;
  } src_sel_t;

  typedef enum logic [1:0] {
    ADV_NONE  = 2'b00,
    ADV_DELAY = 2'b01,
    ADV_OTHER = 2'b10
  } adv_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WAIT    = 3'b001,
    ST_DELAY   = 3'b010,
    ST_SEEK    = 3'b011,
    ST_INHIBIT = 3'b100
  } qual_state_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } ahb_ap_t;
endpackage

// ==== tb/ahb_host.sv ====
// Host model issuing single-word register transfers
`include "delay_trig_params.svh"
module ahb_host (
  // Clock
  input  wire logic        hclk,
  // Bus
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Address phase held until ready, then data phase until ready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Advanced, then delay mode, then time variant
  task automatic sel_time_mode();
    logic [31:0] q;
    xfer(1'b1, `OFS_CTRL, 32'h0000_0001, q);
    xfer(1'b1, `OFS_CTRL, 32'h0000_0003, q);
    xfer(1'b1, `OFS_CTRL, 32'h0000_000B, q);
  endtask
endmodule // ahb_host

// ==== tb/delay_trig_monitor.sv ====
// Port checker for the delay-by-time trigger qualifier
`include "delay_trig_params.svh"
module delay_trig_monitor #(
  parameter int unsigned MAX_DELAY_CYC = 64
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Trigger outputs
  input wire logic [15:0] edge_threshold,
  input wire logic        trig_fire,
  input wire logic        trig_armed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        wr_dp_r;
  logic [7:0]  wa_r;
  logic [31:0] dly_r;
  logic [31:0] arm_cnt_r;
  // Decode of taken requests and of the clamped delay
  wire         rd_take = hsel && htrans[1] && hready && !hwrite;
  wire         lvl_wr  = wr_dp_r && (wa_r == `OFS_LEVEL);
  wire         dly_wr  = wr_dp_r && (wa_r == `OFS_DELAY);
  wire [31:0]  dly_in  = hwdata;
  wire [31:0]  dly_nxt = (dly_in == 32'h0000_0000) ? 32'h0000_0001 :
                         (dly_in > MAX_DELAY_CYC) ? MAX_DELAY_CYC : dly_in;
  // Data phase, delay shadow and armed-cycle count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_r   <= 1'b0;
      wa_r      <= 8'h00;
      dly_r     <= 32'h0000_0001;
      arm_cnt_r <= 32'h0000_0000;
    end else begin
      wr_dp_r   <= hsel && htrans[1] && hready && hwrite;
      wa_r      <= haddr[7:0];
      dly_r     <= dly_wr ? dly_nxt : dly_r;
      arm_cnt_r <= trig_armed ? arm_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_level_slaved: assert property (lvl_wr |=>
    edge_threshold == $past(hwdata[15:0]))
    else $error("threshold not the written level");
  a_level_steady: assert property ($changed(edge_threshold) |->
    $past(lvl_wr)) else $error("threshold changed without a write");
  a_fire_pulse: assert property (trig_fire |=> !trig_fire)
    else $error("fire longer than one cycle");
  a_fire_after_seek: assert property (trig_fire |->
    $past(trig_armed) && !trig_armed) else $error("fire while not armed");
  a_delay_honoured: assert property (trig_fire |->
    arm_cnt_r >= dly_r + 32'h0000_0001) else $error("fire before delay");
  a_rearm_needed: assert property ($fell(trig_armed) |->
    !trig_armed [*2]) else $error("armed again without a new arm");
  // Main scenarios reached
  c_fire: cover property (trig_fire);
  c_armed: cover property ($rose(trig_armed));
  c_level: cover property (lvl_wr);
endmodule // delay_trig_monitor

bind delay_by_time_trigger delay_trig_monitor #(
  .MAX_DELAY_CYC(MAX_DELAY_CYC)
) u_mon (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .edge_threshold, .trig_fire, .trig_armed
);

// ==== tb/tb_delay_by_time_trigger.sv ====
// Self-checking bench for the delay-by-time trigger qualifier
`include "delay_trig_params.svh"
module tb_delay_by_time_trigger;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        two_ch = 1'b0;
  logic        mixed = 1'b1;
  logic [3:0]  acmp = 4'h0;
  logic [15:0] dig = 16'h0000;
  logic        ext = 1'b0;
  logic [31:0] q;
  wire logic   hsel, hwrite, hready, hresp, fire, armed;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  wire logic [15:0] thr;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  row_t rows [16] = '{
    '{`OFS_CTRL, 32'h0000_000B, 32'h0000_000B},
    '{`OFS_CTRL, 32'h0000_0005, 32'h0000_0005},
    '{`OFS_CTRL, 32'h0000_0000, 32'h0000_0000},
    '{`OFS_SLOPES, 32'h0000_0006, 32'h0000_0006},
    '{`OFS_SLOPES, 32'h0000_0003, 32'h0000_0003},
    '{`OFS_ARM_SRC, 32'h0000_0004, 32'h0000_0004},
    '{`OFS_ARM_SRC, 32'h0000_001F, 32'h0000_001F},
    '{`OFS_ARM_SRC, 32'h0000_0020, 32'h0000_001F},
    '{`OFS_ARM_SRC, 32'h0000_0005, 32'h0000_001F},
    '{`OFS_TRIG_SRC, 32'h0000_0010, 32'h0000_0010},
    '{`OFS_DELAY, 32'h0000_0000, 32'h0000_0001},
    '{`OFS_DELAY, 32'h0000_03E8, 32'h0000_0040},
    '{`OFS_LEVEL, 32'h0000_1234, 32'h0000_1234},
    '{`OFS_INHIBIT, 32'h0000_0002, 32'h0000_0002},
    '{`OFS_BAND, 32'h0000_0001, 32'h0000_0001},
    '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000}};

  delay_by_time_trigger #(.MAX_DELAY_CYC(64)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata,
    .variant_two_channel(two_ch), .variant_mixed_signal(mixed),
    .analog_cmp(acmp), .digital_in(dig), .ext_trig_in(ext),
    .edge_threshold(thr), .trig_fire(fire), .trig_armed(armed));
  ahb_host u_host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);

  // Clock and hang guard
  initial forever #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk_w(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    checks++;
    if (g != e) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
    chk_w(nm, e, q);
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  // Edges until fire or armed goes high, 99 if not within 20
  task automatic edges_to(input bit f, output int k);
    k = 99;
    for (int i = 1; i <= 20 && k == 99; i++) begin
      @(posedge hclk);
      #1;
      if ((f ? fire : armed) === 1'b1) k = i;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset();
    rdc("ctrl reset", `OFS_CTRL, 32'h0000_0000);
    rdc("arm src reset", `OFS_ARM_SRC, 32'h0000_0001);
    rdc("slopes reset", `OFS_SLOPES, 32'h0000_0007);
    rdc("delay reset", `OFS_DELAY, 32'h0000_0001);
    chk_w("threshold reset", 32'h0000_8000, {16'h0000, thr});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc("register", rows[i].a, rows[i].e);
    end
    chk_w("threshold", 32'h0000_1234, {16'h0000, thr});
    // Arm on channel 1, trigger on channel 2, five-cycle delay
    wr(`OFS_ARM_SRC, 32'h0000_0001);
    wr(`OFS_TRIG_SRC, 32'h0000_0002);
    wr(`OFS_DELAY, 32'h0000_0005);
    wr(`OFS_BAND, 32'h0000_0000);
    u_host.sel_time_mode();
    @(posedge hclk);
    acmp[0] <= 1'b1;
    edges_to(1'b0, n);
    chk_n("arm latency", 4, n);
    @(posedge hclk);
    acmp[1] <= 1'b1;
    edges_to(1'b1, n);
    chk_n("early trigger", 99, n);
    chk_w("still armed", 32'h0000_0001, {31'h0, armed});
    @(posedge hclk);
    acmp[1] <= 1'b0;
    repeat (5) @(posedge hclk);
    acmp[1] <= 1'b1;
    edges_to(1'b1, n);
    chk_n("fire latency", 4, n);
    rdc("fire count", `OFS_STATUS, 32'h0001_004C);
    // No second fire without a new arm, then arm on a falling edge
    acmp[1] <= 1'b0;
    repeat (5) @(posedge hclk);
    acmp[1] <= 1'b1;
    edges_to(1'b1, n);
    chk_n("fire without arm", 99, n);
    wr(`OFS_SLOPES, 32'h0000_0002);
    wr(`OFS_BAND, 32'h0000_0001);
    @(posedge hclk);
    acmp[0] <= 1'b0;
    edges_to(1'b0, n);
    chk_n("falling arm", 5, n);
    // Two-channel part without digital inputs
    two_ch <= 1'b1;
    mixed <= 1'b0;
    do_reset();
    wr(`OFS_ARM_SRC, 32'h0000_0020);
    rdc("external arm", `OFS_ARM_SRC, 32'h0000_0020);
    wr(`OFS_ARM_SRC, 32'h0000_0003);
    rdc("analog three", `OFS_ARM_SRC, 32'h0000_0020);
    wr(`OFS_ARM_SRC, 32'h0000_0010);
    rdc("digital refused", `OFS_ARM_SRC, 32'h0000_0020);
    u_host.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, q);
    chk_w("error flag", 32'h0000_0008, q & 32'h0000_0008);
    wr(`OFS_STATUS, 32'h0000_0008);
    u_host.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, q);
    chk_w("error cleared", 32'h0000_0000, q & 32'h0000_0008);
    tally_and_finish();
  end
endmodule // tb_delay_by_time_trigger
